// [rtl/tsc_pkg.sv]
package tsc_pkg;

   // Counter and command slot counts
   localparam int NCNT  = 2;
   localparam int NSLOT = 4;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] REG_CFG0   = 8'h00;
   localparam logic [7:0] REG_CFG1   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FINAL0 = 8'h0c;
   localparam logic [7:0] REG_FINAL1 = 8'h10;

   // Configuration register fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_TERM_LSB = 16;

   // Status register fields
   localparam int ST_ERR_BIT = 0;
   localparam int ST_EVT_LSB = 4;
   localparam int ST_RUN_LSB = 8;
   localparam int ST_OVF_LSB = 12;

   // Final value register fields
   localparam int FIN_OVF_BIT = 16;

   // Counter mode codes
   localparam logic [1:0] MODE_EVENTS = 2'h0;
   localparam logic [1:0] MODE_USEC   = 2'h1;
   localparam logic [1:0] MODE_MSEC   = 2'h2;

   // Command codes, event mode
   localparam logic [1:0] CMD_INC   = 2'h0;
   localparam logic [1:0] CMD_RESET = 2'h1;

   // Command codes, time mode
   localparam logic [1:0] CMD_RUN       = 2'h0;
   localparam logic [1:0] CMD_STOP      = 2'h1;
   localparam logic [1:0] CMD_RESET_RUN = 2'h2;

   // Terminating value limits, reset values and counter ceiling
   localparam logic [15:0] TERM_MIN  = 16'h0002;
   localparam logic [15:0] TERM_MAX  = 16'hfffe;
   localparam logic [15:0] TERM_RST  = 16'h0002;
   localparam logic [1:0]  MODE_RST  = 2'h0;
   localparam logic [15:0] COUNT_MAX = 16'hfffe;

   // Time base
   localparam int CLK_PERIOD_NS = 8;
   localparam int USEC_NS       = 1000;
   localparam int USEC_CYCLES   = USEC_NS / CLK_PERIOD_NS;
   localparam int MSEC_US       = 1000;

   // One command request from the sequencer
   typedef struct packed
   {
      logic       valid;
      logic [1:0] code;
   } tsc_cmd_t;

   // Stored per-counter settings
   typedef struct packed
   {
      logic [1:0]  mode;
      logic [15:0] term;
   } tsc_cfg_t;

   // Value captured when acquisition ends
   typedef struct packed
   {
      logic        overflow_indicator;
      logic [15:0] value;
   } tsc_final_t;

endpackage

// [rtl/tsc_counters.sv]
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module tsc_counters
(
   // Clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   rst_n_in,
   // Register port
   input  wire logic [7:0]             addr_in,
   input  wire logic [31:0]            wr_data_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic      [31:0]            rd_data_out,
   // Sequencer side
   input  wire logic                   run_start_in,
   input  wire logic                   acq_active_in,
   input  wire logic                   state_tick_in,
   input  wire logic [1:0]             event_used_in,
   input  tsc_pkg::tsc_cmd_t [1:0][3:0] cmd_in,
   output logic      [1:0]             counter_event_out,
   output logic                        config_error_out
);

   // Reset release
   logic rst_meta_q;
   logic rst_sync_q;

   // Time base
   logic [6:0] us_cnt_q;
   logic       us_tick_q;
   logic [9:0] ms_cnt_q;
   logic       ms_tick_q;

   // Settings and status
   tsc_pkg::tsc_cfg_t   cfg_q   [2];
   logic                err_q;
   logic [1:0]          cfg_wr;
   logic [1:0]          cfg_ok;
   logic [1:0]          mode_chg;

   // Counter state
   logic [15:0]         count_q [2];
   logic [15:0]         count_d [2];
   logic [1:0]          run_q;
   logic [1:0]          run_d;
   logic [1:0]          ovf_q;
   logic [1:0]          ovf_d;
   logic [1:0]          evt_q;
   logic [1:0]          evt_d;
   logic [1:0]          sel_valid;
   logic [1:0]          sel_code [2];

   // Acquisition end and final values
   logic                acq_prev_q;
   tsc_pkg::tsc_final_t final_q [2];

   // Byte offset of a counter's configuration register
   function automatic logic [7:0] cfg_addr(input int idx);
      cfg_addr = (idx == 0) ? tsc_pkg::REG_CFG0 : tsc_pkg::REG_CFG1;
   endfunction

   // Mode code known and terminating value inside the legal window
   function automatic logic cfg_legal(input logic [31:0] d);
      logic [1:0]  m;
      logic [15:0] t;
      m = d[tsc_pkg::CFG_MODE_LSB +: 2];
      t = d[tsc_pkg::CFG_TERM_LSB +: 16];
      cfg_legal = (m != 2'h3) && (t >= tsc_pkg::TERM_MIN)
                  && (t <= tsc_pkg::TERM_MAX);
   endfunction

   // One step up; saturated counters hold, the ceiling overflows
   function automatic logic [16:0] bump(input logic [15:0] c,
                                        input logic        ovf,
                                        input logic        sat);
      if (sat || ovf)
      begin
         bump = {ovf, c};
      end
      else if (c == tsc_pkg::COUNT_MAX)
      begin
         bump = {1'b1, c};
      end
      else
      begin
         bump = {1'b0, c + 16'h0001};
      end
   endfunction

   // Reset is taken asynchronously and released on the clock
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Free-running microsecond and millisecond ticks, never tied to
   // the State clock so time keeps accruing between state cycles
   always_ff @(posedge clock_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         us_cnt_q  <= 7'h00;
         us_tick_q <= 1'b0;
         ms_cnt_q  <= 10'h000;
         ms_tick_q <= 1'b0;
      end
      else
      begin
         us_tick_q <= 1'b0;
         ms_tick_q <= 1'b0;
         if (us_cnt_q == 7'(tsc_pkg::USEC_CYCLES - 1))
         begin
            us_cnt_q  <= 7'h00;
            us_tick_q <= 1'b1;
            if (ms_cnt_q == 10'(tsc_pkg::MSEC_US - 1))
            begin
               ms_cnt_q  <= 10'h000;
               ms_tick_q <= 1'b1;
            end
            else
            begin
               ms_cnt_q <= ms_cnt_q + 10'h001;
            end
         end
         else
         begin
            us_cnt_q <= us_cnt_q + 7'h01;
         end
      end
   end

   // Write decode; an illegal value leaves the stored settings alone
   always_comb
   begin
      for (int i = 0; i < tsc_pkg::NCNT; i++)
      begin
         cfg_wr[i]   = wr_in && (addr_in == cfg_addr(i));
         cfg_ok[i]   = cfg_wr[i] && cfg_legal(wr_data_in);
         mode_chg[i] = cfg_ok[i] && (cfg_q[i].mode
                       != wr_data_in[tsc_pkg::CFG_MODE_LSB +: 2]);
      end
   end

   // Settings: one mode and one terminating value per counter
   always_ff @(posedge clock_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         for (int i = 0; i < tsc_pkg::NCNT; i++)
         begin
            cfg_q[i].mode <= tsc_pkg::MODE_RST;
            cfg_q[i].term <= tsc_pkg::TERM_RST;
         end
      end
      else
      begin
         for (int i = 0; i < tsc_pkg::NCNT; i++)
         begin
            if (cfg_ok[i])
            begin
               cfg_q[i].mode <= wr_data_in[tsc_pkg::CFG_MODE_LSB +: 2];
               cfg_q[i].term <= wr_data_in[tsc_pkg::CFG_TERM_LSB +: 16];
            end
         end
      end
   end

   // Sticky error; a new rejection wins over a clear in one cycle
   always_ff @(posedge clock_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         err_q <= 1'b0;
      end
      else if (|(cfg_wr & ~cfg_ok))
      begin
         err_q <= 1'b1;
      end
      else if (wr_in && (addr_in == tsc_pkg::REG_STATUS)
               && wr_data_in[tsc_pkg::ST_ERR_BIT])
      begin
         err_q <= 1'b0;
      end
   end

   // Pick the lowest-numbered requested slot; later slots are dropped
   always_comb
   begin
      for (int i = 0; i < tsc_pkg::NCNT; i++)
      begin
         sel_valid[i] = 1'b0;
         sel_code[i]  = 2'h0;
         for (int s = tsc_pkg::NSLOT - 1; s >= 0; s--)
         begin
            if (cmd_in[i][s].valid)
            begin
               sel_valid[i] = 1'b1;
               sel_code[i]  = cmd_in[i][s].code;
            end
         end
      end
   end

   // Next counter state; commands act only on a State clock cycle
   always_comb
   begin
      logic        timed;
      logic        unit;
      logic        sat;
      logic        clr;
      logic [16:0] nx;
      timed = 1'b0;
      unit  = 1'b0;
      sat   = 1'b0;
      clr   = 1'b0;
      nx    = 17'h00000;
      for (int i = 0; i < tsc_pkg::NCNT; i++)
      begin
         count_d[i] = count_q[i];
         run_d[i]   = run_q[i];
         ovf_d[i]   = ovf_q[i];
         evt_d[i]   = evt_q[i];
         clr        = 1'b0;
         timed      = (cfg_q[i].mode != tsc_pkg::MODE_EVENTS);
         unit       = (cfg_q[i].mode == tsc_pkg::MODE_USEC)
                      ? us_tick_q : ms_tick_q;
         sat        = event_used_in[i]
                      && (count_q[i] >= cfg_q[i].term);
         nx         = bump(count_q[i], ovf_q[i], sat);
         if (run_start_in)
         begin
            count_d[i] = 16'h0000;
            run_d[i]   = 1'b0;
            ovf_d[i]   = 1'b0;
            evt_d[i]   = 1'b0;
         end
         else
         begin
            if (!acq_active_in || mode_chg[i])
            begin
               run_d[i] = 1'b0;
            end
            else if (state_tick_in && sel_valid[i])
            begin
               if (!timed)
               begin
                  if (sel_code[i] == tsc_pkg::CMD_INC)
                  begin
                     count_d[i] = nx[15:0];
                     ovf_d[i]   = nx[16];
                  end
                  else if (sel_code[i] == tsc_pkg::CMD_RESET)
                  begin
                     count_d[i] = 16'h0000;
                     ovf_d[i]   = 1'b0;
                     clr        = 1'b1;
                  end
               end
               else
               begin
                  case (sel_code[i])
                     tsc_pkg::CMD_RUN:
                     begin
                        run_d[i] = 1'b1;
                     end
                     tsc_pkg::CMD_STOP:
                     begin
                        run_d[i] = 1'b0;
                     end
                     tsc_pkg::CMD_RESET_RUN:
                     begin
                        count_d[i] = 16'h0000;
                        ovf_d[i]   = 1'b0;
                        run_d[i]   = 1'b1;
                        clr        = 1'b1;
                     end
                     default:
                     begin
                        run_d[i] = run_q[i];
                     end
                  endcase
               end
            end
            else if (timed && run_q[i] && unit)
            begin
               count_d[i] = nx[15:0];
               ovf_d[i]   = nx[16];
            end
            // Compare uses the count before this cycle's update, so
            // the flag lags reaching the value by one state cycle
            if (state_tick_in)
            begin
               evt_d[i] = sat && !clr;
            end
         end
      end
   end

   // Counter registers
   always_ff @(posedge clock_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         for (int i = 0; i < tsc_pkg::NCNT; i++)
         begin
            count_q[i] <= 16'h0000;
         end
         run_q <= 2'h0;
         ovf_q <= 2'h0;
         evt_q <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < tsc_pkg::NCNT; i++)
         begin
            count_q[i] <= count_d[i];
         end
         run_q <= run_d;
         ovf_q <= ovf_d;
         evt_q <= evt_d;
      end
   end

   // Capture final values as acquisition ends, for the status area
   always_ff @(posedge clock_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         acq_prev_q <= 1'b0;
         for (int i = 0; i < tsc_pkg::NCNT; i++)
         begin
            final_q[i] <= '0;
         end
      end
      else
      begin
         acq_prev_q <= acq_active_in;
         if (acq_prev_q && !acq_active_in)
         begin
            for (int i = 0; i < tsc_pkg::NCNT; i++)
            begin
               final_q[i].overflow_indicator <= ovf_q[i];
               final_q[i].value <= ovf_q[i] ? 16'h0000
                                            : count_q[i];
            end
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock_in or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         rd_data_out <= 32'h0000_0000;
      end
      else
      begin
         rd_data_out <= 32'h0000_0000;
         if (rd_in)
         begin
            case (addr_in)
               tsc_pkg::REG_CFG0:
               begin
                  rd_data_out <= {cfg_q[0].term, 14'h0000, cfg_q[0].mode};
               end
               tsc_pkg::REG_CFG1:
               begin
                  rd_data_out <= {cfg_q[1].term, 14'h0000, cfg_q[1].mode};
               end
               tsc_pkg::REG_STATUS:
               begin
                  rd_data_out[tsc_pkg::ST_ERR_BIT]      <= err_q;
                  rd_data_out[tsc_pkg::ST_EVT_LSB +: 2] <= evt_q;
                  rd_data_out[tsc_pkg::ST_RUN_LSB +: 2] <= run_q;
                  rd_data_out[tsc_pkg::ST_OVF_LSB +: 2] <= ovf_q;
               end
               tsc_pkg::REG_FINAL0:
               begin
                  rd_data_out <= {15'h0000, final_q[0]};
               end
               tsc_pkg::REG_FINAL1:
               begin
                  rd_data_out <= {15'h0000, final_q[1]};
               end
               default:
               begin
                  rd_data_out <= 32'h0000_0000;  // Unmapped reads zero
               end
            endcase
         end
      end
   end

   // Outputs come straight from flops
   assign counter_event_out = evt_q;
   assign config_error_out  = err_q;

endmodule // tsc_counters

// [testbench/tsc_checker.sv]
`timescale 1ns/1ps
// Port-level watch on the two trigger counters
module tsc_checker
(
   // Clock and reset
   input wire logic                         clock_in,
   input wire logic                         rst_n_in,
   // Register port
   input wire logic [7:0]                   addr_in,
   input wire logic [31:0]                  wr_data_in,
   input wire logic                         wr_in,
   input wire logic                         rd_in,
   input wire logic [31:0]                  rd_data_out,
   // Sequencer side
   input wire logic                         run_start_in,
   input wire logic                         acq_active_in,
   input wire logic                         state_tick_in,
   input wire logic [1:0]                   event_used_in,
   input wire tsc_pkg::tsc_cmd_t [1:0][3:0] cmd_in,
   input wire logic [1:0]                   counter_event_out,
   input wire logic                         config_error_out
);
   // One domain, so one clock and one disable for all
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   // Steps of a rejected configuration entry
   sequence s_cfg_wr;
      wr_in && (addr_in == tsc_pkg::REG_CFG0 || addr_in == tsc_pkg::REG_CFG1);
   endsequence
   sequence s_bad_term;
      s_cfg_wr ##0 (wr_data_in[31:16] < tsc_pkg::TERM_MIN ||
                    wr_data_in[31:16] > tsc_pkg::TERM_MAX);
   endsequence
   sequence s_bad_mode;
      s_cfg_wr ##0 (wr_data_in[1:0] == 2'h3);
   endsequence
   sequence s_err_kept;
      config_error_out ##0
         !(wr_in && addr_in == tsc_pkg::REG_STATUS && wr_data_in[0]);
   endsequence

   AST_BAD_TERM: assert property (s_bad_term |=> config_error_out)
      else $error("out of range value not flagged");
   AST_BAD_MODE: assert property (s_bad_mode |=> config_error_out)
      else $error("illegal mode not flagged");
   AST_ERR_STICKY: assert property (s_err_kept |=> config_error_out)
      else $error("error flag dropped without clear");
   AST_RD_ZERO: assert property (!rd_in |=> rd_data_out == 32'h0)
      else $error("read data outside its cycle");
   AST_UNMAPPED: assert property (rd_in && addr_in > 8'h10 |=>
      rd_data_out == 32'h0)
      else $error("unmapped read not zero");
   // Event only moves on a State cycle, a program start or a setting write
   AST_EVT_TICK_ONLY: assert property (!state_tick_in && !run_start_in &&
      !wr_in |=> $stable(counter_event_out))
      else $error("event moved outside a state cycle");
   AST_EVT0_USED: assert property ($rose(counter_event_out[0]) |->
      $past(state_tick_in) && $past(event_used_in[0]))
      else $error("event 0 rose without a tested state cycle");
   AST_EVT1_USED: assert property ($rose(counter_event_out[1]) |->
      $past(state_tick_in) && $past(event_used_in[1]))
      else $error("event 1 rose without a tested state cycle");
   AST_RUN_START: assert property (run_start_in |=>
      counter_event_out == 2'h0)
      else $error("program start left an event set");
endmodule // tsc_checker

bind tsc_counters tsc_checker u_chk
(
   .clock_in          (clock_in),
   .rst_n_in          (rst_n_in),
   .addr_in           (addr_in),
   .wr_data_in        (wr_data_in),
   .wr_in             (wr_in),
   .rd_in             (rd_in),
   .rd_data_out       (rd_data_out),
   .run_start_in      (run_start_in),
   .acq_active_in     (acq_active_in),
   .state_tick_in     (state_tick_in),
   .event_used_in     (event_used_in),
   .cmd_in            (cmd_in),
   .counter_event_out (counter_event_out),
   .config_error_out  (config_error_out)
);

// [testbench/tsc_seq_model.sv]
`timescale 1ns/1ps
// Sequencer stand-in: one evaluation per State cycle
module tsc_seq_model
(
   // Clock
   input  wire logic                         clock_in,
   // Requests from the bench
   input  wire logic                         tick_req_in,
   input  wire tsc_pkg::tsc_cmd_t [1:0][3:0] cmd_req_in,
   // Sequencer outputs
   output logic                              state_tick_out,
   output tsc_pkg::tsc_cmd_t [1:0][3:0]      cmd_out
);
   logic [23:0] junk_q = 24'h5a5a5a;

   // Junk changes every cycle so stale commands never look held
   always_ff @(posedge clock_in)
   begin
      junk_q <= {junk_q[22:0], ~junk_q[23]};
   end

   // Commands exist only in their State cycle, slots in test order
   assign state_tick_out = tick_req_in;
   assign cmd_out = tick_req_in ? cmd_req_in : junk_q;
endmodule // tsc_seq_model

// [testbench/trigger_sequence_counters_test.sv]
`timescale 1ns/1ps
// Self-checking bench for the trigger counters
module trigger_sequence_counters_test;
   logic                         clock_in = 1'b0;
   logic                         rst_n_in = 1'b0;
   logic [7:0]                   addr_in = 8'h00;
   logic [31:0]                  wr_data_in = 32'h0;
   logic                         wr_in = 1'b0;
   logic                         rd_in = 1'b0;
   logic [31:0]                  rd_data_out;
   logic                         run_start_in = 1'b0;
   logic                         acq_active_in = 1'b0;
   logic                         tick_req = 1'b0;
   logic                         state_tick_in;
   logic [1:0]                   event_used_in = 2'h3;
   tsc_pkg::tsc_cmd_t [1:0][3:0] cmd_req = '0;
   tsc_pkg::tsc_cmd_t [1:0][3:0] cmd_in;
   tsc_pkg::tsc_cmd_t [1:0][3:0] c;
   logic [1:0]                   counter_event_out;
   logic                         config_error_out;
   logic [31:0]                  rng = 32'd41921;
   logic [31:0]                  r;
   logic [31:0]                  bad [3] = '{32'h00010000, 32'hffff0000,
                                             32'h00020003};
   int                           err_total = 0;
   int                           n_tests = 0;
   int                           cyc = 0;
   int                           i;
   int                           s;
   int                           k;
   int                           cnt0;
   logic                         ev0;

   tsc_counters dut
   (
      .clock_in          (clock_in),
      .rst_n_in          (rst_n_in),
      .addr_in           (addr_in),
      .wr_data_in        (wr_data_in),
      .wr_in             (wr_in),
      .rd_in             (rd_in),
      .rd_data_out       (rd_data_out),
      .run_start_in      (run_start_in),
      .acq_active_in     (acq_active_in),
      .state_tick_in     (state_tick_in),
      .event_used_in     (event_used_in),
      .cmd_in            (cmd_in),
      .counter_event_out (counter_event_out),
      .config_error_out  (config_error_out)
   );

   tsc_seq_model u_seq
   (
      .clock_in       (clock_in),
      .tick_req_in    (tick_req),
      .cmd_req_in     (cmd_req),
      .state_tick_out (state_tick_in),
      .cmd_out        (cmd_in)
   );

   // 125 MHz clock and a hang guard well past the expected run
   always #4 clock_in = ~clock_in;
   always @(posedge clock_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         print_verdict();
      end
   end

   task print_verdict();
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      addr_in <= a;
      wr_data_in <= v;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 chk(rd_data_out, exp);
   endtask

   // One State cycle; event has landed when this returns
   task tick(input tsc_pkg::tsc_cmd_t [1:0][3:0] cv);
      @(posedge clock_in);
      cmd_req <= cv;
      tick_req <= 1'b1;
      @(posedge clock_in);
      tick_req <= 1'b0;
      #1;
   endtask

   task acq(input logic a);
      @(posedge clock_in);
      acq_active_in <= a;
      repeat (2) @(posedge clock_in);
   endtask

   function automatic tsc_pkg::tsc_cmd_t [1:0][3:0] one(input int n,
                                                        input logic [1:0] cd);
      tsc_pkg::tsc_cmd_t [1:0][3:0] v;
      v = '0;
      v[n][0].valid = 1'b1;
      v[n][0].code = cd;
      return v;
   endfunction

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Main sequence
   initial
   begin
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      rd(tsc_pkg::REG_CFG0, 32'h00020000);
      rd(tsc_pkg::REG_CFG1, 32'h00020000);
      rd(8'h14, 32'h0);
      // Rejected entries flag and keep the stored settings
      for (i = 0; i < 3; i++)
      begin
         wr(tsc_pkg::REG_CFG0, bad[i]);
         rd(tsc_pkg::REG_STATUS, 32'h1);
         chk(config_error_out, 32'h1);
         wr(tsc_pkg::REG_STATUS, 32'h1);
      end
      rd(tsc_pkg::REG_CFG0, 32'h00020000);
      wr(tsc_pkg::REG_CFG0, 32'hfffe0002);
      rd(tsc_pkg::REG_CFG0, 32'hfffe0002);
      rd(tsc_pkg::REG_STATUS, 32'h0);
      chk(config_error_out, 32'h0);
      wr(tsc_pkg::REG_CFG0, 32'h00030000);
      wr(tsc_pkg::REG_CFG1, 32'h00050001);
      @(posedge clock_in);
      run_start_in <= 1'b1;
      acq_active_in <= 1'b1;
      @(posedge clock_in);
      run_start_in <= 1'b0;
      // Microsecond counter, term 5: run, stop, resume, saturate
      tick(one(1, tsc_pkg::CMD_RESET_RUN));
      // Only counter 1 is running now
      rd(tsc_pkg::REG_STATUS, 32'h200);
      repeat (250) @(posedge clock_in);
      tick('0);
      chk(counter_event_out[1], 32'h0);
      tick(one(1, tsc_pkg::CMD_STOP));
      repeat (1500) @(posedge clock_in);
      tick(one(1, tsc_pkg::CMD_STOP));
      chk(counter_event_out[1], 32'h0);
      tick(one(1, tsc_pkg::CMD_RUN));
      repeat (875) @(posedge clock_in);
      tick(one(1, tsc_pkg::CMD_RUN));
      chk(counter_event_out[1], 32'h1);
      acq(1'b0);
      rd(tsc_pkg::REG_FINAL1, 32'h5);
      acq(1'b1);
      // Reset-and-run on and on keeps the event away
      for (i = 0; i < 3; i++)
      begin
         repeat (700) @(posedge clock_in);
         tick(one(1, tsc_pkg::CMD_RESET_RUN));
         chk(counter_event_out[1], 32'h0);
      end
      tick(one(1, tsc_pkg::CMD_STOP));
      // Random commands on the event counter against the model
      cnt0 = 0;
      ev0 = 1'b0;
      for (i = 0; i < 300; i++)
      begin
         c = '0;
         for (s = 0; s < 4; s++)
         begin
            r = xs();
            c[0][s].valid = r[0];
            c[0][s].code = r[2:1];
         end
         tick(c);
         k = -1;
         for (s = 3; s >= 0; s--)
            if (c[0][s].valid)
               k = s;
         if (k >= 0 && c[0][k].code == tsc_pkg::CMD_RESET)
         begin
            ev0 = 1'b0;
            cnt0 = 0;
         end
         else
         begin
            ev0 = (cnt0 >= 3);
            if (k >= 0 && c[0][k].code == tsc_pkg::CMD_INC && cnt0 < 3)
               cnt0++;
         end
         chk(counter_event_out[0], ev0);
      end
      acq(1'b0);
      rd(tsc_pkg::REG_FINAL0, cnt0);
      // A new program clears both counters
      @(posedge clock_in);
      run_start_in <= 1'b1;
      @(posedge clock_in);
      run_start_in <= 1'b0;
      acq(1'b1);
      acq(1'b0);
      chk(counter_event_out, 32'h0);
      rd(tsc_pkg::REG_FINAL0, 32'h0);
      rd(tsc_pkg::REG_FINAL1, 32'h0);
      // Untested counter neither saturates nor raises its event
      acq(1'b1);
      event_used_in <= 2'h2;
      for (i = 0; i < 4; i++)
      begin
         tick(one(0, tsc_pkg::CMD_INC));
         chk(counter_event_out[0], 32'h0);
      end
      acq(1'b0);
      rd(tsc_pkg::REG_FINAL0, 32'h4);
      wr(tsc_pkg::REG_CFG1, 32'h00050002);
      rd(tsc_pkg::REG_CFG1, 32'h00050002);
      print_verdict();
   end
endmodule // trigger_sequence_counters_test
